// *** rtl/gpio_low.sv ***
// low port group top: axi4-lite register slave and three port banks
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
module gpio_low #(
  parameter int AW = gpio_low_pkg::ADDR_W
) (
  input  wire logic                                     aclk,
  input  wire logic                                     aresetn,
  input  wire logic                                     awvalid,
  output logic                                          awready,
  input  wire logic [AW-1:0]                            awaddr,
  input  wire logic [2:0]                               awprot,
  input  wire logic                                     wvalid,
  output logic                                          wready,
  input  wire logic [31:0]                              wdata,
  input  wire logic [3:0]                               wstrb,
  output logic                                          bvalid,
  input  wire logic                                     bready,
  output logic [1:0]                                    bresp,
  input  wire logic                                     arvalid,
  output logic                                          arready,
  input  wire logic [AW-1:0]                            araddr,
  input  wire logic [2:0]                               arprot,
  output logic                                          rvalid,
  input  wire logic                                     rready,
  output logic [31:0]                                   rdata,
  output logic [1:0]                                    rresp,
  input  wire logic [gpio_low_pkg::NPORT-1:0][7:0]      pin_in,
  output gpio_low_pkg::pins_s [gpio_low_pkg::NPORT-1:0] pads,
  output logic [7:0]                                    analog_in_pins_sel,
  output logic                                          feedback_resistor_cut,
  input  wire logic                                     conv_busy
);

  gpio_low_pkg::top_st_s             st_q;
  gpio_low_pkg::top_st_s             st_d;
  logic [gpio_low_pkg::NPORT-1:0]    wr_out;
  logic [gpio_low_pkg::NPORT-1:0]    wr_dir;
  logic [gpio_low_pkg::NPORT-1:0]    wr_pu;
  logic [gpio_low_pkg::NPORT-1:0][7:0] b_out;
  logic [gpio_low_pkg::NPORT-1:0][7:0] b_dir;
  logic [gpio_low_pkg::NPORT-1:0][7:0] b_pu;
  logic [gpio_low_pkg::NPORT-1:0][7:0] b_rd;
  logic                              do_wr;
  logic                              wr_lane0;
  logic                              wr_hit;
  logic                              rd_hit;
  logic [7:0]                        rd_byte;
  logic [7:0]                        wa;
  logic [7:0]                        ra;

  assign wa       = st_q.awaddr[7:0];
  assign ra       = araddr[7:0];
  assign do_wr    = st_q.aw_full & st_q.w_full & ~st_q.bvalid;
  assign wr_lane0 = do_wr & st_q.wstrb[0];

  // write decode and read mux; pin registers ignore writes
  always_comb
  begin
    wr_out  = '0;
    wr_dir  = '0;
    wr_pu   = '0;
    wr_hit  = (wa == gpio_low_pkg::OFS_ANALOG) || (wa == gpio_low_pkg::OFS_CLK)
              || (wa == gpio_low_pkg::OFS_STAT);
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    for (int k = 0; k < gpio_low_pkg::NPORT; k++)
    begin
      if ((wa & 8'hf0) == gpio_low_pkg::PORT_BASE[k])
        wr_hit = 1'b1;
      wr_out[k] = wr_lane0 && wa == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_OUT);
      wr_dir[k] = wr_lane0 && wa == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_DIR);
      wr_pu[k]  = wr_lane0 && wa == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_PU);
    end
    unique case (ra)
      gpio_low_pkg::OFS_ANALOG: rd_byte = st_q.analog_sel;
      gpio_low_pkg::OFS_CLK:    rd_byte = st_q.clk_ctrl;
      gpio_low_pkg::OFS_STAT:   rd_byte = {7'h00, st_q.conv_err};
      default:
      begin
        rd_hit = 1'b0;
        for (int k = 0; k < gpio_low_pkg::NPORT; k++)
        begin
          if (ra == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_OUT))
          begin
            rd_byte = b_out[k];
            rd_hit  = 1'b1;
          end
          if (ra == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_DIR))
          begin
            rd_byte = b_dir[k];
            rd_hit  = 1'b1;
          end
          if (ra == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_PU))
          begin
            rd_byte = b_pu[k];
            rd_hit  = 1'b1;
          end
          if (ra == (gpio_low_pkg::PORT_BASE[k] | gpio_low_pkg::OFS_PIN))
          begin
            rd_byte = b_rd[k];
            rd_hit  = 1'b1;
          end
        end
      end
    endcase
  end

  // bus handshakes, control registers and conversion-hazard flag
  always_comb
  begin
    st_d = st_q;
    if (awvalid && st_q.awready)
    begin
      st_d.aw_full = 1'b1;
      st_d.awaddr  = awaddr;
    end
    if (wvalid && st_q.wready)
    begin
      st_d.w_full = 1'b1;
      st_d.wdata  = wdata;
      st_d.wstrb  = wstrb;
    end
    if (st_q.bvalid && bready)
      st_d.bvalid = 1'b0;
    if (do_wr)
    begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = wr_hit ? gpio_low_pkg::RESP_OKAY : gpio_low_pkg::RESP_SLVERR;
      if (wr_lane0 && wa == gpio_low_pkg::OFS_ANALOG)
        st_d.analog_sel = st_q.wdata[7:0];
      if (wr_lane0 && wa == gpio_low_pkg::OFS_CLK)
        st_d.clk_ctrl = st_q.wdata[7:0]; // [RULE_04]
      if (wr_lane0 && wa == gpio_low_pkg::OFS_STAT && st_q.wdata[gpio_low_pkg::CONV_ERR_BIT])
        st_d.conv_err = 1'b0;
    end
    // a pin write during conversion spoils accuracy; set beats clear
    if (conv_busy && ((wr_out | wr_dir) != '0))
      st_d.conv_err = 1'b1; // [RULE_07] [RULE_08]
    if (st_q.arready && arvalid)
    begin
      st_d.rvalid  = 1'b1;
      st_d.arready = 1'b0;
      st_d.rdata   = {24'h000000, rd_byte};
      st_d.rresp   = rd_hit ? gpio_low_pkg::RESP_OKAY : gpio_low_pkg::RESP_SLVERR;
    end
    if (st_q.rvalid && rready)
    begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
    st_d.awready = ~st_d.aw_full;
    st_d.wready  = ~st_d.w_full;
  end

  // single register stage for the whole front end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q         <= '0;
      st_q.awready <= 1'b1;
      st_q.wready  <= 1'b1;
      st_q.arready <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // banks differ only by which pins are input-only or analog capable
  for (genvar k = 0; k < gpio_low_pkg::NPORT; k++)
  begin : g_bank
    port_bank #(
      .FIXED (gpio_low_pkg::FIXED_IN[k]),
      .CAP   (gpio_low_pkg::ANA_CAP[k])
    ) u_bank (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .wr_out     (wr_out[k]),
      .wr_dir     (wr_dir[k]),
      .wr_pu      (wr_pu[k]),
      .wdata      (st_q.wdata[7:0]),
      .analog_sel (st_q.analog_sel), // [RULE_02] [RULE_06]
      .pin_in     (pin_in[k]),
      .pad        (pads[k]),
      .out_q      (b_out[k]),
      .dir_q      (b_dir[k]),
      .pu_q       (b_pu[k]),
      .rd_q       (b_rd[k])
    );
  end

  assign awready               = st_q.awready;
  assign wready                = st_q.wready;
  assign arready               = st_q.arready;
  assign bvalid                = st_q.bvalid;
  assign bresp                 = st_q.bresp;
  assign rvalid                = st_q.rvalid;
  assign rdata                 = st_q.rdata;
  assign rresp                 = st_q.rresp;
  assign analog_in_pins_sel    = st_q.analog_sel;
  assign feedback_resistor_cut = st_q.clk_ctrl[gpio_low_pkg::FBR_BIT]; // [RULE_04]

  property p_port1_dir;
    @(posedge aclk) disable iff (!aresetn)
    wr_dir[1] |=> pads[1].oe == ~$past(st_q.wdata[7:0]);
  endproperty
  a_port1_dir: assert property (p_port1_dir) else $error("port 1 direction lost"); // [RULE_02]

  property p_conv_flag;
    @(posedge aclk) disable iff (!aresetn)
    (conv_busy && wr_out != '0) |=> st_q.conv_err;
  endproperty
  a_conv_flag: assert property (p_conv_flag) else $error("conversion hazard missed"); // [RULE_07]

  property p_bresp_hold;
    @(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp));
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

  property p_read_latency;
    @(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> (rvalid && !arready);
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  c_write: cover property (@(posedge aclk) disable iff (!aresetn) bvalid && bready);
  c_read: cover property (@(posedge aclk) disable iff (!aresetn) rvalid && rready);
  c_analog: cover property (@(posedge aclk) disable iff (!aresetn) st_q.analog_sel != 8'h00);
  c_hazard: cover property (@(posedge aclk) disable iff (!aresetn) st_q.conv_err);

endmodule // gpio_low

// *** rtl/gpio_low_pkg.sv ***
// constants, layouts and carrier types for the low port group
// Operation
// [RULE_01] port 0 bidirectional pins set direction per bit
// [RULE_02] port 1: eight bits, per-bit direction, analog capable
// [RULE_03] pull-up only on inputs, software enabled
// [RULE_04] software sets feedback cut before subclock pin input
// [RULE_05] software sets port 1 input before analog use
// [RULE_06] analog pin drops its pull-up automatically
// [RULE_07] no latch writes during a conversion
// [RULE_08] no output level changes during a conversion
// [RULE_09] every pin is input after reset
// [RULE_10] input-only port 0 pins never drive
package gpio_low_pkg;

  localparam int          NPORT      = 3;
  localparam int          ADDR_W     = 8;

  // per-port register block, each register one aligned word
  localparam logic [2:0][7:0] PORT_BASE = {8'h20, 8'h10, 8'h00};
  localparam logic [7:0]  OFS_OUT    = 8'h00;
  localparam logic [7:0]  OFS_DIR    = 8'h04;
  localparam logic [7:0]  OFS_PU     = 8'h08;
  localparam logic [7:0]  OFS_PIN    = 8'h0c;
  localparam logic [7:0]  OFS_ANALOG = 8'h30;
  localparam logic [7:0]  OFS_CLK    = 8'h34;
  localparam logic [7:0]  OFS_STAT   = 8'h38;

  // direction register: 1 = input
  localparam logic [7:0]  DIR_RST    = 8'hff;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [2:0][7:0] FIXED_IN  = {8'h00, 8'h00, 8'h81};
  localparam logic [2:0][7:0] ANA_CAP   = {8'h00, 8'hff, 8'h00};
  localparam int          FBR_BIT    = 6;
  localparam int          CONV_ERR_BIT = 0;

  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // pad controls of one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pu;
  } pins_s;

  // state of one port bank
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] dir;
    logic [7:0] pu;
    logic [7:0] rd;
    pins_s      pad;
  } bank_st_s;

  // state of the register front end
  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              arready;
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [7:0]        analog_sel;
    logic [7:0]        clk_ctrl;
    logic              conv_err;
  } top_st_s;

endpackage

// *** rtl/port_bank.sv ***
// one 8-bit port: output latch, direction, pull-up and pad control
`timescale 1ns/10ps
module port_bank #(
  parameter logic [7:0] FIXED = 8'h00,
  parameter logic [7:0] CAP   = 8'h00
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                wr_out,
  input  wire logic                wr_dir,
  input  wire logic                wr_pu,
  input  wire logic [7:0]          wdata,
  input  wire logic [7:0]          analog_sel,
  input  wire logic [7:0]          pin_in,
  output gpio_low_pkg::pins_s      pad,
  output logic [7:0]               out_q,
  output logic [7:0]               dir_q,
  output logic [7:0]               pu_q,
  output logic [7:0]               rd_q
);

  gpio_low_pkg::bank_st_s st_q;
  gpio_low_pkg::bank_st_s st_d;

  // next state; pads follow the registers in the same edge
  always_comb
  begin
    st_d = st_q;
    if (wr_out)
      st_d.out = wdata;
    if (wr_dir)
      st_d.dir = wdata | FIXED; // [RULE_01] [RULE_10]
    if (wr_pu)
      st_d.pu = wdata;
    st_d.pad.out = st_d.out;
    st_d.pad.oe  = ~st_d.dir & ~FIXED; // [RULE_10]
    // analog use overrides software pull-up, inputs only
    st_d.pad.pu  = st_d.dir & st_d.pu & ~(analog_sel & CAP); // [RULE_03] [RULE_06]
    // inputs read the pin, outputs read back the latch
    st_d.rd      = (st_d.dir & pin_in) | (~st_d.dir & st_d.out);
  end

  // all pins come up as undriven inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q.out <= gpio_low_pkg::BYTE_ZERO;
      st_q.dir <= gpio_low_pkg::DIR_RST; // [RULE_09]
      st_q.pu  <= gpio_low_pkg::BYTE_ZERO;
      st_q.rd  <= gpio_low_pkg::BYTE_ZERO;
      st_q.pad <= '0;
    end
    else
      st_q <= st_d;
  end

  assign pad   = st_q.pad;
  assign out_q = st_q.out;
  assign dir_q = st_q.dir;
  assign pu_q  = st_q.pu;
  assign rd_q  = st_q.rd;

  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
    wr_dir |=> pad.oe == (~$past(wdata) & ~FIXED);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction write not applied"); // [RULE_01]

  property p_pu_input_only;
    @(posedge aclk) disable iff (!aresetn)
    (pad.pu & pad.oe) == 8'h00;
  endproperty
  a_pu_input_only: assert property (p_pu_input_only) else $error("pull-up on output"); // [RULE_03]

  property p_analog_pu_off;
    @(posedge aclk) disable iff (!aresetn)
    ##1 (pad.pu & $past(analog_sel) & CAP) == 8'h00;
  endproperty
  a_analog_pu_off: assert property (p_analog_pu_off) else $error("pull-up on analog pin"); // [RULE_06]

  property p_reset_input;
    @(posedge aclk)
    (aresetn && !$past(aresetn)) |-> (pad.oe == 8'h00 && dir_q == 8'hff);
  endproperty
  a_reset_input: assert property (p_reset_input) else $error("pin driven after reset"); // [RULE_09]

  property p_fixed_input;
    @(posedge aclk) disable iff (!aresetn)
    (pad.oe & FIXED) == 8'h00 && (dir_q & FIXED) == FIXED;
  endproperty
  a_fixed_input: assert property (p_fixed_input) else $error("input-only pin drives"); // [RULE_10]

  property p_pu_follows;
    @(posedge aclk) disable iff (!aresetn)
    (wr_pu && !wr_dir && (analog_sel & CAP) == 8'h00) |=> pad.pu == ($past(wdata) & dir_q);
  endproperty
  a_pu_follows: assert property (p_pu_follows) else $error("pull-up write not applied"); // [RULE_03]

  c_pu_on: cover property (@(posedge aclk) disable iff (!aresetn) pad.pu != 8'h00);

endmodule // port_bank

// *** verif/pin_model.sv ***
// board-side pin model: driven pads, pull-ups and floating lines
`timescale 1ns/10ps
module pin_model (
  input  wire gpio_low_pkg::pins_s [gpio_low_pkg::NPORT-1:0] pads,
  input  wire logic [2:0][7:0]                               float_lvl,
  output logic [2:0][7:0]                                    pin_in
);
  // undriven lines without pull-up follow the bench's changing pattern
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      pin_in[k] = (pads[k].oe & pads[k].out) | (~pads[k].oe & (pads[k].pu | float_lvl[k]));
    end
  end
endmodule // pin_model

// *** verif/tb_gpio_low.sv ***
// self-checking bench for the low port group
`timescale 1ns/10ps
module tb_gpio_low;
  logic                      aclk = 1'b0;
  logic                      aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                      arvalid, arready, rvalid, rready, fbr_cut, conv_busy;
  logic [7:0]                awaddr, araddr, ana_sel;
  logic [31:0]               wdata, rdata;
  logic [3:0]                wstrb;
  logic [1:0]                bresp, rresp;
  logic [2:0][7:0]           pin_in, float_lvl;
  gpio_low_pkg::pins_s [2:0] pads;
  logic [7:0]                e_out[3], e_dir[3], e_pu[3], e_ana;
  int                        fail_count, samples_checked, seed, k;

  always #10 aclk = ~aclk;

  gpio_low dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .pin_in(pin_in), .pads(pads),
    .analog_in_pins_sel(ana_sel), .feedback_resistor_cut(fbr_cut), .conv_busy(conv_busy));

  pin_model pins (.pads(pads), .float_lvl(float_lvl), .pin_in(pin_in));

  function automatic logic [7:0] ad(input int p, input logic [7:0] ofs);
    return gpio_low_pkg::PORT_BASE[p] + ofs;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // both channels offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    logic awh, wh, bh;
    logic [1:0] r;
    @(posedge aclk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {24'h000000, d}; bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge aclk);
      awh = awvalid & awready; wh = wvalid & wready; bh = bvalid; r = bresp;
      @(posedge aclk);
      if (awh) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh)
      begin
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin fail_count++; final_report; end
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int n;
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(negedge aclk);
      ah = arvalid & arready; rh = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      if (rh)
      begin
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) begin fail_count++; final_report; end
    chk(d, {24'h000000, ed});
    chk({30'h0, r}, {30'h0, er});
  endtask

  // expected pad controls and readback worked out from the bench copy
  task automatic check_port(input int p);
    logic [7:0] dr, pe;
    dr = e_dir[p] | gpio_low_pkg::FIXED_IN[p];
    pe = dr & e_pu[p] & ~((p == 1) ? e_ana : 8'h00);
    @(negedge aclk);
    chk({24'h0, pads[p].oe}, {24'h0, ~dr});
    chk({24'h0, pads[p].pu}, {24'h0, pe});
    chk({24'h0, pads[p].out & ~dr}, {24'h0, e_out[p] & ~dr});
    rd_reg(ad(p, gpio_low_pkg::OFS_DIR), dr, gpio_low_pkg::RESP_OKAY);
    rd_reg(ad(p, gpio_low_pkg::OFS_PIN), (dr & (pe | float_lvl[p])) | (~dr & e_out[p]),
      gpio_low_pkg::RESP_OKAY);
  endtask

  initial
  begin
    seed = 13297;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf;
    conv_busy = 1'b0; float_lvl = 24'ha5c35a; e_ana = 8'h00;
    for (int p = 0; p < 3; p++)
    begin
      e_out[p] = 8'h00; e_dir[p] = 8'hff; e_pu[p] = 8'h00;
    end
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk({31'h0, fbr_cut}, 32'h0);
    // subclock pin used as plain input only after the feedback cut is set
    wr(gpio_low_pkg::OFS_CLK, 8'h40, gpio_low_pkg::RESP_OKAY);
    rd_reg(gpio_low_pkg::OFS_CLK, 8'h40, gpio_low_pkg::RESP_OKAY);
    chk({31'h0, fbr_cut}, 32'h1);
    $display("test clock ctrl done");
    // pin reads of port 0 only once the subclock pin may serve as input
    for (int p = 0; p < 3; p++) check_port(p);
    $display("test reset done");
    // first three passes all-output except port 0's input-only pins, the rest random per port
    for (int i = 0; i < 24; i++)
    begin
      k = (i < 3) ? i : $unsigned($random(seed)) % 3;
      e_out[k] = 8'($random(seed));
      e_dir[k] = (i < 3) ? 8'h00 : 8'($random(seed));
      e_pu[k] = 8'($random(seed));
      float_lvl[k] <= 8'($random(seed));
      wr(ad(k, gpio_low_pkg::OFS_OUT), e_out[k], gpio_low_pkg::RESP_OKAY);
      wr(ad(k, gpio_low_pkg::OFS_DIR), e_dir[k], gpio_low_pkg::RESP_OKAY);
      wr(ad(k, gpio_low_pkg::OFS_PU), e_pu[k], gpio_low_pkg::RESP_OKAY);
      check_port(k);
    end
    $display("test direction and pull-up done");
    // port 1 set to input before analog use, pull-ups then released
    e_dir[1] = 8'hff; e_pu[1] = 8'hff;
    wr(ad(1, gpio_low_pkg::OFS_DIR), e_dir[1], gpio_low_pkg::RESP_OKAY);
    wr(ad(1, gpio_low_pkg::OFS_PU), e_pu[1], gpio_low_pkg::RESP_OKAY);
    for (int i = 0; i < 3; i++)
    begin
      e_ana = (i == 2) ? 8'h00 : 8'($random(seed));
      wr(gpio_low_pkg::OFS_ANALOG, e_ana, gpio_low_pkg::RESP_OKAY);
      check_port(1);
      chk({24'h0, ana_sel}, {24'h0, e_ana});
      rd_reg(gpio_low_pkg::OFS_ANALOG, e_ana, gpio_low_pkg::RESP_OKAY);
    end
    $display("test analog release done");
    // latch and direction writes during a conversion get flagged
    conv_busy <= 1'b1;
    wr(ad(2, gpio_low_pkg::OFS_PU), e_pu[2], gpio_low_pkg::RESP_OKAY);
    rd_reg(gpio_low_pkg::OFS_STAT, 8'h00, gpio_low_pkg::RESP_OKAY);
    wr(ad(2, gpio_low_pkg::OFS_OUT), e_out[2], gpio_low_pkg::RESP_OKAY);
    rd_reg(gpio_low_pkg::OFS_STAT, 8'h01, gpio_low_pkg::RESP_OKAY);
    conv_busy <= 1'b0;
    wr(gpio_low_pkg::OFS_STAT, 8'h01, gpio_low_pkg::RESP_OKAY);
    rd_reg(gpio_low_pkg::OFS_STAT, 8'h00, gpio_low_pkg::RESP_OKAY);
    conv_busy <= 1'b1;
    wr(ad(0, gpio_low_pkg::OFS_DIR), e_dir[0], gpio_low_pkg::RESP_OKAY);
    conv_busy <= 1'b0;
    rd_reg(gpio_low_pkg::OFS_STAT, 8'h01, gpio_low_pkg::RESP_OKAY);
    $display("test conversion guard done");
    // unmapped places outside the port blocks answer with an error and zero data
    rd_reg(8'h3c, 8'h00, gpio_low_pkg::RESP_SLVERR);
    wr(8'h40, 8'h5a, gpio_low_pkg::RESP_SLVERR);
    rd_reg(8'hfc, 8'h00, gpio_low_pkg::RESP_SLVERR);
    $display("test unmapped done");
    // a write without byte lane 0 answers but leaves the direction alone
    wstrb <= 4'he;
    wr(ad(2, gpio_low_pkg::OFS_DIR), ~e_dir[2], gpio_low_pkg::RESP_OKAY);
    wstrb <= 4'hf;
    check_port(2);
    $display("test byte lane done");
    // reset in mid-run puts every pin back to an undriven input
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    e_ana = 8'h00;
    for (int p = 0; p < 3; p++)
    begin
      e_out[p] = 8'h00; e_dir[p] = 8'hff; e_pu[p] = 8'h00;
    end
    @(negedge aclk);
    chk({31'h0, fbr_cut}, 32'h0);
    chk({24'h0, ana_sel}, 32'h0);
    wr(gpio_low_pkg::OFS_CLK, 8'h40, gpio_low_pkg::RESP_OKAY);
    for (int p = 0; p < 3; p++) check_port(p);
    rd_reg(gpio_low_pkg::OFS_STAT, 8'h00, gpio_low_pkg::RESP_OKAY);
    $display("test mid-run reset done");
    final_report;
  end
endmodule // tb_gpio_low
